// File: hdl/dcfb_consts.vh
`ifndef DCFB_CONSTS_VH
`define DCFB_CONSTS_VH

// item select codes on the item access port
`define DCFB_ITEM_ACCEL 3'h0
`define DCFB_ITEM_DECEL 3'h1
`define DCFB_ITEM_TL1 3'h2
`define DCFB_ITEM_TL2 3'h3
`define DCFB_ITEM_DOUT 3'h4
`define DCFB_ITEM_AOUT 3'h5

// ranges in units of the minimum step (0.1 s, 1 %)
`define DCFB_ACCEL_MAX 16'h8ca0
`define DCFB_TRUNC_FROM 16'h03e8
`define DCFB_TL_MIN 16'h0014
`define DCFB_TL_MAX 16'h00c8
`define DCFB_TL_NOLIMIT 16'h03e7

// reset values
`define DCFB_ACCEL_RST 16'h0064
`define DCFB_DECEL_RST 16'h0064
`define DCFB_TL_RST 16'h03e7
`define DCFB_DOUT_RST 16'h0000
`define DCFB_AOUT_RST 16'h0000

// terminal-function assignment codes
`define DCFB_FN_INT_HOLD 7'h22
`define DCFB_FN_LOCAL 7'h23
`define DCFB_FN_RUN_PERMIT 7'h26
`define DCFB_FN_CONDENS 7'h27
`define DCFB_FN_SEQ50 7'h28
`define DCFB_FN_SEQ60 7'h29
`define DCFB_FN_PULSE_RX 7'h2c
`define DCFB_FN_RETURN 7'h2d
`define DCFB_FN_RUN_SEL 7'h57
`define DCFB_FN_FWD_RUN_CMD_SECOND 7'h58
`define DCFB_FN_REV_RUN_CMD_SECOND 7'h59

`endif

// File: hdl/dcfb_data_bank.v
`include "dcfb_consts.vh"
`default_nettype none

// Functional notes
// - decode listed terminal-function assignment codes
// - unassigned function is off; run permit on
// - integral hold link only; local select terminal only
// - decode 88/89 run commands, 44/45 modes
// - accel/decel 0.0 to 3600.0 s, read/write
// - reject out-of-range write, flag range error on host writes and host reads of unmapped items only
// - accel/decel write updates internal parameters
// - torque limits 20..200 or 999, update params
// - keypad changes visible in the items
// - drop fraction of large accel/decel values
// - host digital out word drives terminals
// - host analog out signed, drives meter outputs
// - host outputs ignore drive running state
module dcfb_data_bank (
    input wire i_core_clk,
    input wire i_nrst,
    input wire i_item_wr,
    input wire i_item_rd,
    input wire [2:0] i_item_sel,
    input wire [15:0] i_item_wdata,
    output reg o_item_ack,
    output reg [15:0] o_item_rdata,
    output reg o_range_err,
    input wire i_kp_wr,
    input wire [2:0] i_kp_sel,
    input wire [15:0] i_kp_wdata,
    input wire [4:0] i_term_pins,
    input wire [4:0] i_link_term,
    input wire [34:0] i_term_assign,
    output reg [15:0] o_internal_accel_param,
    output reg [15:0] o_internal_decel_param,
    output reg [15:0] o_internal_drive_torque_limit,
    output reg [15:0] o_internal_ctrl_torque_limit,
    output reg [15:0] o_host_digital_out,
    output reg [15:0] o_analog_meter_out,
    output reg [15:0] o_pulse_meter_out,
    output reg o_integral_hold_cmd,
    output reg o_local_select_cmd,
    output reg o_run_permit_cmd,
    output reg o_condensation_guard_cmd,
    output reg o_mains_switch_seq_50,
    output reg o_mains_switch_seq_60,
    output reg o_serial_pulse_rx_mode,
    output reg o_return_mode_cmd,
    output reg o_run_cmd_select,
    output reg o_fwd_run_cmd_second,
    output reg o_rev_run_cmd_second
);

    // range check per item, values in step units
    function fn_in_range;
        input [2:0] sel;
        input [15:0] val;
        begin
            case (sel)
                `DCFB_ITEM_ACCEL, `DCFB_ITEM_DECEL:
                    fn_in_range = (val <= `DCFB_ACCEL_MAX);
                `DCFB_ITEM_TL1, `DCFB_ITEM_TL2:
                    fn_in_range = ((val >= `DCFB_TL_MIN) &&
                        (val <= `DCFB_TL_MAX)) ||
                        (val == `DCFB_TL_NOLIMIT);
                `DCFB_ITEM_DOUT, `DCFB_ITEM_AOUT:
                    fn_in_range = 1'b1;
                default:
                    fn_in_range = 1'b0;
            endcase
        end
    endfunction

    // large times keep whole seconds only
    function [15:0] fn_trunc;
        input [2:0] sel;
        input [15:0] val;
        begin
            if (((sel == `DCFB_ITEM_ACCEL) || (sel == `DCFB_ITEM_DECEL))
                && (val >= `DCFB_TRUNC_FROM))
                fn_trunc = val - (val % 16'h000a);
            else
                fn_trunc = val;
        end
    endfunction

    // or of every source assigned to a code, default when none is
    function fn_decode;
        input [6:0] code;
        input [34:0] asg;
        input [4:0] term;
        input [4:0] comm;
        input use_term;
        input use_comm;
        input dflt;
        integer k;
        reg hit;
        reg val;
        begin
            hit = 1'b0;
            val = 1'b0;
            for (k = 0; k < 5; k = k + 1)
            begin
                if (asg[k*7 +: 7] == code)
                begin
                    hit = 1'b1;
                    val = val | (use_term & term[k]) |
                        (use_comm & comm[k]);
                end
            end
            fn_decode = hit ? val : dflt;
        end
    endfunction

    reg [4:0] term_meta_reg;
    reg [4:0] term_sync_reg;
    reg host_ok;
    reg kp_ok;
    reg wr_en;
    reg [2:0] wr_sel;
    reg [15:0] wr_val;
    reg [15:0] rd_val;

    // pins come from outside the clock domain
    always @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            term_meta_reg <= 5'h00;
            term_sync_reg <= 5'h00;
        end
        else
        begin
            term_meta_reg <= i_term_pins;
            term_sync_reg <= term_meta_reg;
        end
    end

    // host write wins; a keypad write in the same cycle is dropped
    always @*
    begin
        host_ok = i_item_wr && fn_in_range(i_item_sel, i_item_wdata);
        kp_ok = i_kp_wr && fn_in_range(i_kp_sel, i_kp_wdata);
        wr_en = host_ok || (kp_ok && !i_item_wr);
        wr_sel = i_item_wr ? i_item_sel : i_kp_sel;
        wr_val = i_item_wr ? fn_trunc(i_item_sel, i_item_wdata) :
            fn_trunc(i_kp_sel, i_kp_wdata);
    end

    // read mux over the items themselves
    always @*
    begin
        case (i_item_sel)
            `DCFB_ITEM_ACCEL: rd_val = o_internal_accel_param;
            `DCFB_ITEM_DECEL: rd_val = o_internal_decel_param;
            `DCFB_ITEM_TL1: rd_val = o_internal_drive_torque_limit;
            `DCFB_ITEM_TL2: rd_val = o_internal_ctrl_torque_limit;
            `DCFB_ITEM_DOUT: rd_val = o_host_digital_out;
            `DCFB_ITEM_AOUT: rd_val = o_analog_meter_out;
            default: rd_val = 16'h0000;
        endcase
    end

    // items double as the internal parameters, so no copy can go stale
    always @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_internal_accel_param <= `DCFB_ACCEL_RST;
            o_internal_decel_param <= `DCFB_DECEL_RST;
            o_internal_drive_torque_limit <= `DCFB_TL_RST;
            o_internal_ctrl_torque_limit <= `DCFB_TL_RST;
            o_host_digital_out <= `DCFB_DOUT_RST;
            o_analog_meter_out <= `DCFB_AOUT_RST;
            o_pulse_meter_out <= `DCFB_AOUT_RST;
        end
        else if (wr_en)
        begin
            case (wr_sel)
                `DCFB_ITEM_ACCEL:
                    o_internal_accel_param <= wr_val;
                `DCFB_ITEM_DECEL:
                    o_internal_decel_param <= wr_val;
                `DCFB_ITEM_TL1:
                    o_internal_drive_torque_limit <= wr_val;
                `DCFB_ITEM_TL2:
                    o_internal_ctrl_torque_limit <= wr_val;
                `DCFB_ITEM_DOUT:
                    o_host_digital_out <= wr_val;
                `DCFB_ITEM_AOUT:
                begin
                    o_analog_meter_out <= wr_val;
                    o_pulse_meter_out <= wr_val;
                end
                default:
                    o_host_digital_out <= o_host_digital_out;
            endcase
        end
    end

    // answer one cycle after a host access; write takes priority
    always @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_item_ack <= 1'b0;
            o_item_rdata <= 16'h0000;
            o_range_err <= 1'b0;
        end
        else
        begin
            o_item_ack <= i_item_wr || i_item_rd;
            o_range_err <= (i_item_wr && !host_ok) ||
                (i_item_rd && !i_item_wr &&
                (i_item_sel > `DCFB_ITEM_AOUT));
            if (i_item_rd && !i_item_wr)
                o_item_rdata <= rd_val;
        end
    end

    // terminal-function decode, registered so outputs come from flops
    always @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_integral_hold_cmd <= 1'b0;
            o_local_select_cmd <= 1'b0;
            o_run_permit_cmd <= 1'b1;
            o_condensation_guard_cmd <= 1'b0;
            o_mains_switch_seq_50 <= 1'b0;
            o_mains_switch_seq_60 <= 1'b0;
            o_serial_pulse_rx_mode <= 1'b0;
            o_return_mode_cmd <= 1'b0;
            o_run_cmd_select <= 1'b0;
            o_fwd_run_cmd_second <= 1'b0;
            o_rev_run_cmd_second <= 1'b0;
        end
        else
        begin
            o_integral_hold_cmd <= fn_decode(`DCFB_FN_INT_HOLD,
                i_term_assign, term_sync_reg, i_link_term,
                1'b0, 1'b1, 1'b0);
            o_local_select_cmd <= fn_decode(`DCFB_FN_LOCAL,
                i_term_assign, term_sync_reg, i_link_term,
                1'b1, 1'b0, 1'b0);
            o_run_permit_cmd <= fn_decode(`DCFB_FN_RUN_PERMIT,
                i_term_assign, term_sync_reg, i_link_term,
                1'b1, 1'b1, 1'b1);
            o_condensation_guard_cmd <= fn_decode(`DCFB_FN_CONDENS,
                i_term_assign, term_sync_reg, i_link_term,
                1'b1, 1'b1, 1'b0);
            o_mains_switch_seq_50 <= fn_decode(`DCFB_FN_SEQ50,
                i_term_assign, term_sync_reg, i_link_term,
                1'b1, 1'b1, 1'b0);
            o_mains_switch_seq_60 <= fn_decode(`DCFB_FN_SEQ60,
                i_term_assign, term_sync_reg, i_link_term,
                1'b1, 1'b1, 1'b0);
            o_serial_pulse_rx_mode <= fn_decode(`DCFB_FN_PULSE_RX,
                i_term_assign, term_sync_reg, i_link_term,
                1'b0, 1'b1, 1'b0);
            o_return_mode_cmd <= fn_decode(`DCFB_FN_RETURN,
                i_term_assign, term_sync_reg, i_link_term,
                1'b1, 1'b1, 1'b0);
            o_run_cmd_select <= fn_decode(`DCFB_FN_RUN_SEL,
                i_term_assign, term_sync_reg, i_link_term,
                1'b1, 1'b1, 1'b0);
            o_fwd_run_cmd_second <= fn_decode(`DCFB_FN_FWD_RUN_CMD_SECOND,
                i_term_assign, term_sync_reg, i_link_term,
                1'b1, 1'b1, 1'b0);
            o_rev_run_cmd_second <= fn_decode(`DCFB_FN_REV_RUN_CMD_SECOND,
                i_term_assign, term_sync_reg, i_link_term,
                1'b1, 1'b1, 1'b0);
        end
    end

endmodule // dcfb_data_bank

`default_nettype wire

// File: verification/dcfb_asserts.sv
`include "dcfb_consts.vh"
`default_nettype none
module dcfb_asserts (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_item_wr,
    input wire logic i_item_rd,
    input wire logic [2:0] i_item_sel,
    input wire logic [15:0] i_item_wdata,
    input wire logic o_item_ack,
    input wire logic o_range_err,
    input wire logic [15:0] o_internal_accel_param,
    input wire logic [15:0] o_internal_drive_torque_limit,
    input wire logic [15:0] o_host_digital_out,
    input wire logic [15:0] o_analog_meter_out,
    input wire logic [15:0] o_pulse_meter_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    // every request answered exactly one edge later
    chk_ack_one_cycle: assert property (
        o_item_ack == $past(i_item_wr | i_item_rd))
        else $error("ack not one cycle after request");
    // the error flag only ever rides on an answer
    chk_err_with_ack: assert property (
        o_range_err |-> o_item_ack)
        else $error("range error without ack");
    chk_unmapped_err: assert property (
        (i_item_wr | i_item_rd) && i_item_sel > 3'h5 |=> o_range_err)
        else $error("unmapped item not refused");
    // accel item stays in range and drops the fraction when large
    chk_accel_in_range: assert property (
        o_internal_accel_param <= `DCFB_ACCEL_MAX)
        else $error("accel item above range");
    chk_accel_trunc: assert property (
        o_internal_accel_param >= `DCFB_TRUNC_FROM |->
        o_internal_accel_param % 16'h000a == 16'h0000)
        else $error("accel fraction kept");
    chk_accel_write: assert property (
        i_item_wr && i_item_sel == 3'h0 &&
        i_item_wdata < `DCFB_TRUNC_FROM |=>
        o_internal_accel_param == $past(i_item_wdata))
        else $error("accel write not stored");
    chk_accel_refuse: assert property (
        i_item_wr && i_item_sel == 3'h0 &&
        i_item_wdata > `DCFB_ACCEL_MAX |=>
        o_range_err && $stable(o_internal_accel_param))
        else $error("out of range accel stored");
    chk_torque_range: assert property (
        (o_internal_drive_torque_limit >= 16'h0014 &&
        o_internal_drive_torque_limit <= 16'h00c8) ||
        o_internal_drive_torque_limit == 16'h03e7)
        else $error("torque limit out of range");
    chk_dout_follow: assert property (
        i_item_wr && i_item_sel == 3'h4 |=>
        o_host_digital_out == $past(i_item_wdata))
        else $error("digital out not written");
    chk_meters_same: assert property (
        o_analog_meter_out == o_pulse_meter_out)
        else $error("meter outputs differ");
endmodule // dcfb_asserts
`default_nettype wire

// File: verification/dcfb_host_model.sv
`default_nettype none
module dcfb_host_model (
    input wire logic i_core_clk,
    input wire logic i_ack,
    input wire logic i_err,
    input wire logic [15:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [2:0] o_sel,
    output logic [15:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_sel = 3'h0;
        o_wdata = 16'h0000;
    end
    // one-cycle request pulse, answer taken when ack shows
    task automatic access(input logic w, input logic [2:0] s,
            input logic [15:0] d, output logic [15:0] q, output logic e);
        int n;
        n = 0;
        @(posedge i_core_clk);
        o_wr <= w;
        o_rd <= !w;
        o_sel <= s;
        o_wdata <= d;
        @(posedge i_core_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        // answer launched at this edge is taken at the next one
        do
        begin
            @(posedge i_core_clk);
            n++;
        end
        while (i_ack !== 1'b1 && n < 4);
        q = i_rdata;
        // a missing answer poisons the flag so the caller sees a mismatch
        e = (i_ack === 1'b1) ? i_err : 1'bx;
    endtask
endmodule // dcfb_host_model
`default_nettype wire

// File: verification/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_core_clk = 1'b0, i_nrst = 1'b0, wr, rd, ack, err, i_kp_wr = 1'b0;
    logic [2:0] sel, i_kp_sel = 3'h0;
    logic [15:0] wd, rdat, i_kp_wdata = 16'h0000;
    logic [15:0] acc, dec, tl1, tl2, dout, am, pm;
    logic [4:0] i_term_pins = 5'h00, i_link_term = 5'h00;
    logic [34:0] i_term_assign = 35'h0;
    wire logic [10:0] cmds;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    dcfb_host_model u_host (.i_core_clk(i_core_clk), .i_ack(ack), .i_err(err),
        .i_rdata(rdat), .o_wr(wr), .o_rd(rd), .o_sel(sel), .o_wdata(wd));
    dcfb_data_bank uut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_item_wr(wr),
        .i_item_rd(rd), .i_item_sel(sel), .i_item_wdata(wd), .o_item_ack(ack),
        .o_item_rdata(rdat), .o_range_err(err), .i_kp_wr(i_kp_wr),
        .i_kp_sel(i_kp_sel), .i_kp_wdata(i_kp_wdata),
        .i_term_pins(i_term_pins),
        .i_link_term(i_link_term), .i_term_assign(i_term_assign),
        .o_internal_accel_param(acc), .o_internal_decel_param(dec),
        .o_internal_drive_torque_limit(tl1),
        .o_internal_ctrl_torque_limit(tl2),
        .o_host_digital_out(dout), .o_analog_meter_out(am),
        .o_pulse_meter_out(pm),
        .o_integral_hold_cmd(cmds[10]), .o_local_select_cmd(cmds[9]),
        .o_run_permit_cmd(cmds[8]), .o_condensation_guard_cmd(cmds[7]),
        .o_mains_switch_seq_50(cmds[6]), .o_mains_switch_seq_60(cmds[5]),
        .o_serial_pulse_rx_mode(cmds[4]), .o_return_mode_cmd(cmds[3]),
        .o_run_cmd_select(cmds[2]), .o_fwd_run_cmd_second(cmds[1]),
        .o_rev_run_cmd_second(cmds[0]));
    initial
    begin
        forever #25 i_core_clk = ~i_core_clk;
    end
    // hang guard: far above what the scenarios need
    always @(posedge i_core_clk)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    // host access; read data judged only on reads
    task automatic acc_chk(logic w, logic [2:0] s, logic [15:0] d, logic e);
        logic [15:0] q;
        logic ge;
        u_host.access(w, s, d, q, ge);
        chk("range_err", {15'h0, ge}, {15'h0, e});
        if (!w)
            chk("rdata", q, d);
    endtask
    task automatic t_reset_vals();
        logic [15:0] rv [6] = '{16'h0064, 16'h0064, 16'h03e7, 16'h03e7,
            16'h0000, 16'h0000};
        for (int i = 0; i < 6; i++)
            acc_chk(1'b0, i[2:0], rv[i], 1'b0);
        acc_chk(1'b0, 3'h6, 16'h0000, 1'b1);
    endtask
    task automatic t_accel();
        acc_chk(1'b1, 3'h0, 16'h0032, 1'b0);
        chk("accel_small", acc, 16'h0032);
        acc_chk(1'b1, 3'h0, 16'h04d2, 1'b0);
        acc_chk(1'b0, 3'h0, 16'h04ce, 1'b0);
        acc_chk(1'b1, 3'h0, 16'h8ca0, 1'b0);
        acc_chk(1'b1, 3'h0, 16'h8ca1, 1'b1);
        chk("accel", acc, 16'h8ca0);
        acc_chk(1'b1, 3'h1, 16'h2329, 1'b0);
        chk("decel_trunc", dec, 16'h2328);
        acc_chk(1'b1, 3'h1, 16'h0005, 1'b0);
        chk("decel", dec, 16'h0005);
    endtask
    task automatic t_torque();
        logic [15:0] v [6] = '{16'h0013, 16'h0014, 16'h00c8, 16'h00c9,
            16'h03e7, 16'h03e6};
        logic e [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 6; i++)
            acc_chk(1'b1, 3'h3, v[i], e[i]);
        chk("tl2", tl2, 16'h03e7);
        acc_chk(1'b1, 3'h2, 16'h0014, 1'b0);
        chk("tl1", tl1, 16'h0014);
    endtask
    task automatic t_outs();
        acc_chk(1'b1, 3'h4, 16'hffff, 1'b0);
        chk("dout", dout, 16'hffff);
        acc_chk(1'b1, 3'h5, 16'h8000, 1'b0);
        chk("fma", am, 16'h8000);
        chk("fmp", pm, 16'h8000);
        acc_chk(1'b0, 3'h5, 16'h8000, 1'b0);
    endtask
    // keypad path change must show in the item
    task automatic t_keypad();
        @(posedge i_core_clk);
        i_kp_wr <= 1'b1;
        i_kp_sel <= 3'h1;
        i_kp_wdata <= 16'h012c;
        @(posedge i_core_clk);
        // out-of-range keypad value is dropped silently
        i_kp_wdata <= 16'h8ca1;
        @(posedge i_core_clk);
        i_kp_wr <= 1'b0;
        acc_chk(1'b0, 3'h1, 16'h012c, 1'b0);
        chk("kp_refused", dec, 16'h012c);
    endtask
    task automatic t_cmds();
        logic [6:0] c [11] = '{7'h22, 7'h23, 7'h26, 7'h27, 7'h28, 7'h29,
            7'h2c, 7'h2d, 7'h57, 7'h58, 7'h59};
        logic [10:0] x;
        for (int k = 0; k < 11; k++)
        begin
            @(posedge i_core_clk);
            i_term_assign <= {28'h0, c[k]};
            i_link_term <= 5'h01;
            repeat (3) @(posedge i_core_clk);
            x = (c[k] == 7'h23) ? 11'h100 : (11'h100 | (11'h400 >> k));
            chk("cmds_link", {5'h0, cmds}, {5'h0, x});
        end
        // pin source: hold and pulse rx ignored, local select taken
        i_link_term <= 5'h00;
        i_term_pins <= 5'h07;
        i_term_assign <= {14'h0000, 7'h2c, 7'h23, 7'h22};
        repeat (5) @(posedge i_core_clk);
        chk("cmds_pin", {5'h0, cmds}, 16'h0300);
        i_term_pins <= 5'h00;
        i_term_assign <= {28'h0000000, 7'h26};
        repeat (5) @(posedge i_core_clk);
        chk("permit_off", {5'h0, cmds}, 16'h0000);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        t_reset_vals();
        t_accel();
        t_torque();
        t_outs();
        t_keypad();
        t_cmds();
        report_and_stop();
    end
endmodule // tb
bind dcfb_data_bank dcfb_asserts u_chk (.*);
`default_nettype wire
